// ### verilog/cftf_top.sv
// cftf_top: flush-cache-ext and format-track command engine behind an avalon slave
//
// Behaviour
// - command code EAh makes the device write all write-cached data to the media.
// - the extended flush reports good completion only after every cached write is on the media.
// - command code 50h formats exactly one logical track chosen by the address registers.
// - formatting writes zeros into every good sector of the track, losing old contents.
// - formatting does no read-back verification of the zeroed sectors.
// - any descriptor table received is ignored and every sector of the track is zeroed.
// - the track is always laid out the same way, 1:1 interleave with internal relative addressing.
// - at completion in block-address mode the current address is returned in those same fields.
// - a block address beyond the valid range ends the format command with the abort flag set.
// - in block-address mode the whole logical track containing the given address is formatted.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module cftf_top
    import cftf_pkg::*;
#(
    parameter int       CYLS   = 16383,
    parameter int       HEADS  = 16,
    parameter int       SPT    = 63,
    parameter bit       DEV_ID = 1'b0
) (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // avalon-mm slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // interrupt
    output logic             o_irq,
    // media cache flush
    output logic             o_flush_req,
    input  wire logic        i_flush_done,
    // media zero-fill sector writes
    output logic             o_sec_req,
    output logic [27:0]      o_sec_lba,
    output logic [7:0]       o_sec_wdata,
    input  wire logic        i_sec_ack
);

    localparam logic [27:0] SPT_L   = 28'(SPT);
    localparam logic [27:0] HEADS_L = 28'(HEADS);
    localparam logic [27:0] CYLS_L  = 28'(CYLS);
    localparam logic [27:0] MAX_LBA = 28'(CYLS * HEADS * SPT);

    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        cftf_state_t           state;
        logic                  bsy;
        logic                  flush;
        logic                  lba_mode;
        logic [7:0]            feat;
        logic [7:0]            err;
        logic [7:0]            seccnt;
        logic [7:0]            secnum;
        logic [7:0]            cyl_lo;
        logic [7:0]            cyl_hi;
        logic [7:0]            drvhead;
        logic [CFTF_IRQ_W-1:0] irq_sts;
        logic [CFTF_IRQ_W-1:0] irq_mask;
        logic [15:0]           tbl_cnt;
        logic                  seq_go;
        logic [27:0]           seq_lba;
    } cftf_regs_t;

    cftf_regs_t r_r;
    cftf_regs_t r_nxt;

    logic        seq_busy;
    logic        seq_done;
    logic [27:0] seq_last;

    ////////////////////////////////////////////////////////////////////////////////
    // geometric address to block address of the first sector of that track
    function automatic logic [27:0] chs_track_lba(input logic [15:0] cyl, input logic [3:0] hd);
        logic [27:0] trk;
        trk = 28'(cyl) * HEADS_L + 28'(hd);
        return trk * SPT_L;
    endfunction

    // status byte assembled from engine state
    function automatic logic [7:0] status_byte(input cftf_regs_t s);
        logic [7:0] v;
        v               = 8'h00;
        v[CFTF_STS_BSY] = s.bsy;
        v[CFTF_STS_RDY] = ~s.bsy;
        v[CFTF_STS_DSC] = 1'b1;
        v[CFTF_STS_ERR] = (s.err != 8'h00);
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus, command decode, completion and interrupt logic
    always_comb begin
        logic        req;
        logic        wr_now;
        logic        lo_be;
        logic [7:0]  wb;
        logic [27:0] req_lba;
        logic [15:0] cyl;
        logic [3:0]  head;
        logic [CFTF_IRQ_W-1:0] ev;
        logic [CFTF_IRQ_W-1:0] clr;
        logic        drv_ok;

        req     = i_avs_read | i_avs_write;
        wr_now  = i_avs_write & r_r.ack;
        lo_be   = i_avs_byteenable[0];
        wb      = i_avs_writedata[7:0];
        cyl     = {r_r.cyl_hi, r_r.cyl_lo};
        head    = r_r.drvhead[3:0];
        req_lba = {head, r_r.cyl_hi, r_r.cyl_lo, r_r.secnum};
        ev      = '0;
        clr     = '0;
        drv_ok  = (r_r.drvhead[CFTF_DH_DEV] == DEV_ID);

        r_nxt        = r_r;
        r_nxt.seq_go = 1'b0;

        // one wait state: answer on the second edge of every request
        r_nxt.ack = req & ~r_r.ack;

        // read data captured on the first edge, standing when waitrequest drops
        if (i_avs_read && !r_r.ack) begin
            r_nxt.rdata = 32'h0000_0000;
            unique case (i_avs_address)
                CFTF_OFS_FEAT_ERR: r_nxt.rdata[7:0] = r_r.err;
                CFTF_OFS_SECCNT:   r_nxt.rdata[7:0] = r_r.seccnt;
                CFTF_OFS_SECNUM:   r_nxt.rdata[7:0] = r_r.secnum;
                CFTF_OFS_CYL_LO:   r_nxt.rdata[7:0] = r_r.cyl_lo;
                CFTF_OFS_CYL_HI:   r_nxt.rdata[7:0] = r_r.cyl_hi;
                CFTF_OFS_DRVHEAD:  r_nxt.rdata[7:0] = r_r.drvhead;
                CFTF_OFS_CMD_STS:  r_nxt.rdata[7:0] = status_byte(r_r);
                CFTF_OFS_IRQ_STS:  r_nxt.rdata[CFTF_IRQ_W-1:0] = r_r.irq_sts;
                CFTF_OFS_IRQ_MASK: r_nxt.rdata[CFTF_IRQ_W-1:0] = r_r.irq_mask;
                CFTF_OFS_TBL_CNT:  r_nxt.rdata[15:0] = r_r.tbl_cnt;
                default:           r_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // block register writes; the task file is locked while busy
        if (wr_now && lo_be) begin
            unique case (i_avs_address)
                CFTF_OFS_FEAT_ERR: if (!r_r.bsy) r_nxt.feat = wb;
                CFTF_OFS_SECCNT:   if (!r_r.bsy) r_nxt.seccnt = wb;
                CFTF_OFS_SECNUM:   if (!r_r.bsy) r_nxt.secnum = wb;
                CFTF_OFS_CYL_LO:   if (!r_r.bsy) r_nxt.cyl_lo = wb;
                CFTF_OFS_CYL_HI:   if (!r_r.bsy) r_nxt.cyl_hi = wb;
                CFTF_OFS_DRVHEAD:  if (!r_r.bsy) r_nxt.drvhead = wb;
                CFTF_OFS_IRQ_STS:  clr = wb[CFTF_IRQ_W-1:0];
                CFTF_OFS_IRQ_MASK: r_nxt.irq_mask = wb[CFTF_IRQ_W-1:0];
                CFTF_OFS_DATA: begin
                    // table bytes are counted and dropped
                    r_nxt.tbl_cnt = r_r.tbl_cnt + 16'h0001;
                end
                default: ;
            endcase
        end

        // command issue; a command to the other drive or while busy is ignored
        if (wr_now && lo_be && i_avs_address == CFTF_OFS_CMD_STS && !r_r.bsy && drv_ok) begin
            r_nxt.err      = 8'h00;
            r_nxt.lba_mode = r_r.drvhead[CFTF_DH_LBA];
            unique case (wb)
                CFTF_CMD_FLUSH_EXT: begin
                    r_nxt.bsy   = 1'b1;
                    r_nxt.flush = 1'b1;
                    r_nxt.state = CFTF_FLUSH;
                end
                CFTF_CMD_FMT_TRACK: begin
                    r_nxt.tbl_cnt = 16'h0000;
                    if (r_r.drvhead[CFTF_DH_LBA]) begin
                        if (req_lba >= MAX_LBA) begin
                            r_nxt.err[CFTF_ERR_ABT] = 1'b1;
                            ev[CFTF_IRQ_DONE]       = 1'b1;
                            ev[CFTF_IRQ_ERR]        = 1'b1;
                        end else begin
                            // align down to the start of the containing track
                            r_nxt.seq_lba = req_lba - (req_lba % SPT_L);
                            r_nxt.seq_go  = 1'b1;
                            r_nxt.bsy     = 1'b1;
                            r_nxt.state   = CFTF_FMT;
                        end
                    end else if (28'(cyl) >= CYLS_L || 28'(head) >= HEADS_L) begin
                        r_nxt.err[CFTF_ERR_IDN] = 1'b1;
                        ev[CFTF_IRQ_DONE]       = 1'b1;
                        ev[CFTF_IRQ_ERR]        = 1'b1;
                    end else begin
                        r_nxt.seq_lba = chs_track_lba(cyl, head);
                        r_nxt.seq_go  = 1'b1;
                        r_nxt.bsy     = 1'b1;
                        r_nxt.state   = CFTF_FMT;
                    end
                end
                default: begin
                    // unsupported code ends at once with abort
                    r_nxt.err[CFTF_ERR_ABT] = 1'b1;
                    ev[CFTF_IRQ_DONE]       = 1'b1;
                    ev[CFTF_IRQ_ERR]        = 1'b1;
                end
            endcase
        end

        // command completion
        unique case (r_r.state)
            CFTF_IDLE: ;
            CFTF_FLUSH: begin
                // good status held off until the media confirms the flush
                if (i_flush_done) begin
                    r_nxt.flush       = 1'b0;
                    r_nxt.bsy         = 1'b0;
                    r_nxt.state       = CFTF_IDLE;
                    ev[CFTF_IRQ_DONE] = 1'b1;
                end
            end
            CFTF_FMT: begin
                if (seq_done) begin
                    r_nxt.bsy         = 1'b0;
                    r_nxt.state       = CFTF_IDLE;
                    ev[CFTF_IRQ_DONE] = 1'b1;
                    if (r_r.lba_mode) begin
                        r_nxt.secnum       = seq_last[7:0];
                        r_nxt.cyl_lo       = seq_last[15:8];
                        r_nxt.cyl_hi       = seq_last[23:16];
                        r_nxt.drvhead[3:0] = seq_last[27:24];
                    end
                end
            end
        endcase

        // sticky events, a new event wins over a clear in the same cycle
        r_nxt.irq_sts = (r_r.irq_sts & ~clr) | ev;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_r          <= '0;
            r_r.state    <= CFTF_IDLE;
            r_r.feat     <= CFTF_RST_FEAT;
            r_r.err      <= CFTF_RST_ERR;
            r_r.seccnt   <= CFTF_RST_SECCNT;
            r_r.secnum   <= CFTF_RST_SECNUM;
            r_r.cyl_lo   <= CFTF_RST_CYL;
            r_r.cyl_hi   <= CFTF_RST_CYL;
            r_r.drvhead  <= CFTF_RST_DRVHEAD;
            r_r.irq_sts  <= CFTF_RST_IRQ;
            r_r.irq_mask <= CFTF_RST_IRQ;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // track walker
    cftf_zero_seq #(
        .LBA_W (28),
        .SPT   (SPT)
    ) u_seq (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_start     (r_r.seq_go),
        .i_first_lba (r_r.seq_lba),
        .o_busy      (seq_busy),
        .o_done      (seq_done),
        .o_last_lba  (seq_last),
        .o_sec_req   (o_sec_req),
        .o_sec_lba   (o_sec_lba),
        .i_sec_ack   (i_sec_ack)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~r_r.ack;
    assign o_avs_readdata    = r_r.rdata;
    assign o_irq             = |(r_r.irq_sts & r_r.irq_mask);
    assign o_flush_req       = r_r.flush;
    assign o_sec_wdata       = r_r.feat & 8'h00;

endmodule

// ### pkg/cftf_pkg.sv
// cftf_pkg: register map, field positions, reset values and command codes
package cftf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the avalon slave, one aligned word each
    localparam logic [7:0] CFTF_OFS_FEAT_ERR = 8'h00; // write feature, read error
    localparam logic [7:0] CFTF_OFS_SECCNT   = 8'h04;
    localparam logic [7:0] CFTF_OFS_SECNUM   = 8'h08;
    localparam logic [7:0] CFTF_OFS_CYL_LO   = 8'h0C;
    localparam logic [7:0] CFTF_OFS_CYL_HI   = 8'h10;
    localparam logic [7:0] CFTF_OFS_DRVHEAD  = 8'h14;
    localparam logic [7:0] CFTF_OFS_CMD_STS  = 8'h18; // write command, read status
    localparam logic [7:0] CFTF_OFS_IRQ_STS  = 8'h1C; // sticky events, write one to clear
    localparam logic [7:0] CFTF_OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] CFTF_OFS_DATA     = 8'h24; // format table sink
    localparam logic [7:0] CFTF_OFS_TBL_CNT  = 8'h28; // bytes received on the data port

    ////////////////////////////////////////////////////////////////////////////////
    // status bit positions
    localparam int CFTF_STS_BSY = 7;
    localparam int CFTF_STS_RDY = 6;
    localparam int CFTF_STS_DSC = 4;
    localparam int CFTF_STS_ERR = 0;
    // error bit positions
    localparam int CFTF_ERR_IDN = 4;
    localparam int CFTF_ERR_ABT = 2;
    // drive/head fields
    localparam int CFTF_DH_LBA  = 6;
    localparam int CFTF_DH_DEV  = 4;
    // interrupt event bits
    localparam int CFTF_IRQ_DONE = 0;
    localparam int CFTF_IRQ_ERR  = 1;
    localparam int CFTF_IRQ_W    = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CFTF_RST_FEAT    = 8'h00;
    localparam logic [7:0] CFTF_RST_ERR     = 8'h00;
    localparam logic [7:0] CFTF_RST_SECCNT  = 8'h01;
    localparam logic [7:0] CFTF_RST_SECNUM  = 8'h01;
    localparam logic [7:0] CFTF_RST_CYL     = 8'h00;
    localparam logic [7:0] CFTF_RST_DRVHEAD = 8'hA0;
    localparam logic [1:0] CFTF_RST_IRQ     = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] CFTF_CMD_FLUSH_EXT = 8'hEA;
    localparam logic [7:0] CFTF_CMD_FMT_TRACK = 8'h50;

    // command engine states
    typedef enum logic [1:0] {
        CFTF_IDLE,
        CFTF_FLUSH,
        CFTF_FMT
    } cftf_state_t;

endpackage

// ### verilog/cftf_zero_seq.sv
// cftf_zero_seq: walks one track issuing zero-fill sector writes to the media
`timescale 1ns/1ps
module cftf_zero_seq
    import cftf_pkg::*;
#(
    parameter int LBA_W = 28,
    parameter int SPT   = 63
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    // control
    input  wire logic             i_start,
    input  wire logic [LBA_W-1:0] i_first_lba,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [LBA_W-1:0]      o_last_lba,
    // media sector write port, data is always zero
    output logic                  o_sec_req,
    output logic [LBA_W-1:0]      o_sec_lba,
    input  wire logic             i_sec_ack
);

    localparam logic [15:0] LAST_IDX = 16'(SPT - 1);

    typedef struct packed {
        logic             busy;
        logic             done;
        logic [LBA_W-1:0] lba;
        logic [15:0]      left;
    } cftf_seq_t;

    cftf_seq_t r_r;
    cftf_seq_t r_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // one write per sector, each sector in order: fixed 1:1 layout, no read-back
    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        if (i_start && !r_r.busy) begin
            r_nxt.busy = 1'b1;
            r_nxt.lba  = i_first_lba;
            r_nxt.left = LAST_IDX;
        end else if (r_r.busy && i_sec_ack) begin
            if (r_r.left == 16'h0000) begin
                r_nxt.busy = 1'b0;
                r_nxt.done = 1'b1;
            end else begin
                r_nxt.lba  = r_r.lba + LBA_W'(1);
                r_nxt.left = r_r.left - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs
    assign o_busy     = r_r.busy;
    assign o_done     = r_r.done;
    assign o_last_lba = r_r.lba;
    assign o_sec_req  = r_r.busy;
    assign o_sec_lba  = r_r.lba;

endmodule

// ### verif/cftf_monitor.sv
// cftf_monitor: port-level checks of the flush and track-format engine
`timescale 1ns/1ps
module cftf_monitor
    import cftf_pkg::*;
#(
    parameter int CYLS  = 16383,
    parameter int HEADS = 16,
    parameter int SPT   = 63
) (
    // clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    // media side
    input wire logic        o_flush_req,
    input wire logic        i_flush_done,
    input wire logic        o_sec_req,
    input wire logic [27:0] o_sec_lba,
    input wire logic [7:0]  o_sec_wdata,
    input wire logic        i_sec_ack
);
    int ack_cnt_r;

    default clocking mon_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // count sector acks within one track run
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_cnt_r <= 0;
        end else begin
            ack_cnt_r <= !o_sec_req ? 0 : ack_cnt_r + int'(i_sec_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    flush_hold_a: assert property (o_flush_req && !i_flush_done |=> o_flush_req)
        else $error("flush dropped before media done");
    flush_end_a: assert property (o_flush_req && i_flush_done |=> !o_flush_req)
        else $error("flush held after media done");
    zero_data_a: assert property (o_sec_req |-> o_sec_wdata == 8'h00)
        else $error("format data not zero");
    lba_step_a: assert property (o_sec_req && i_sec_ack
        |=> !o_sec_req || o_sec_lba == $past(o_sec_lba) + 28'h1)
        else $error("sector address not sequential");
    lba_hold_a: assert property (o_sec_req && !i_sec_ack |=> o_sec_req && $stable(o_sec_lba))
        else $error("sector request changed before ack");
    track_align_a: assert property ($rose(o_sec_req) |-> (o_sec_lba % SPT) == 0)
        else $error("track run not aligned");
    track_len_a: assert property (ack_cnt_r <= SPT)
        else $error("more sectors than one track");
    track_end_a: assert property (o_sec_req && i_sec_ack && ack_cnt_r == SPT - 1 |=> !o_sec_req)
        else $error("track run did not stop");
    one_job_a: assert property (!(o_flush_req && o_sec_req))
        else $error("flush and format at once");
endmodule

bind cftf_top cftf_monitor #(.CYLS(CYLS), .HEADS(HEADS), .SPT(SPT)) mon_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_flush_req(o_flush_req),
    .i_flush_done(i_flush_done), .o_sec_req(o_sec_req), .o_sec_lba(o_sec_lba),
    .o_sec_wdata(o_sec_wdata), .i_sec_ack(i_sec_ack));

// ### verif/cftf_media_model.sv
// cftf_media_model: media that acks zero-fill writes and cache flushes
`timescale 1ns/1ps
module cftf_media_model (
    // clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // requests and pacing
    input  wire logic        i_flush_req,
    input  wire logic        i_sec_req,
    input  wire logic [27:0] i_sec_lba,
    input  wire logic [7:0]  i_sec_wdata,
    input  wire logic [3:0]  i_delay,
    // answers
    output logic             o_flush_done,
    output logic             o_sec_ack
);
    logic [3:0]  wait_r;
    logic [31:0] zeroed_r;
    int          wr_cnt_r;
    int          flush_cnt_r;

    // answer each request after i_delay idle cycles, one-cycle pulses
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_sec_ack, o_flush_done, wait_r, zeroed_r} <= '0;
            wr_cnt_r <= 0;
            flush_cnt_r <= 0;
        end else begin
            o_sec_ack <= 1'b0;
            o_flush_done <= 1'b0;
            if ((i_sec_req || i_flush_req) && !o_sec_ack && !o_flush_done) begin
                wait_r <= (wait_r < i_delay) ? wait_r + 4'h1 : 4'h0;
                if (wait_r >= i_delay) begin
                    o_sec_ack <= i_sec_req;
                    o_flush_done <= i_flush_req;
                    flush_cnt_r <= flush_cnt_r + int'(i_flush_req);
                    wr_cnt_r <= wr_cnt_r + int'(i_sec_req);
                    if (i_sec_req && i_sec_wdata == 8'h00) begin
                        zeroed_r[i_sec_lba[4:0]] <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ### verif/testbench.sv
// testbench: register-level tests of the flush and track-format engine
`timescale 1ns/1ps
module testbench;
    import cftf_pkg::*;
    localparam logic [7:0] OFS [10] = '{CFTF_OFS_FEAT_ERR, CFTF_OFS_SECCNT,
        CFTF_OFS_SECNUM, CFTF_OFS_CYL_LO, CFTF_OFS_CYL_HI, CFTF_OFS_DRVHEAD,
        CFTF_OFS_CMD_STS, CFTF_OFS_IRQ_STS, CFTF_OFS_IRQ_MASK, 8'h30};
    localparam logic [7:0] RSTV [10] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hA0,
        8'h50, 8'h00, 8'h00, 8'h00};
    logic        clk = 1'b0;
    logic        rst_n;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wq;
    logic        irq;
    logic        flush_req;
    logic        flush_done;
    logic        sec_req;
    logic [27:0] sec_lba;
    logic [7:0]  sec_wdata;
    logic        sec_ack;
    logic [3:0]  delay;
    logic [31:0] rd_v;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #2 clk = ~clk;

    cftf_top #(.CYLS(4), .HEADS(2), .SPT(4)) dut_u (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .o_irq(irq),
        .o_flush_req(flush_req), .i_flush_done(flush_done), .o_sec_req(sec_req),
        .o_sec_lba(sec_lba), .o_sec_wdata(sec_wdata), .i_sec_ack(sec_ack));

    cftf_media_model media_u (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_flush_req(flush_req), .i_sec_req(sec_req),
        .i_sec_lba(sec_lba), .i_sec_wdata(sec_wdata), .i_delay(delay),
        .o_flush_done(flush_done), .o_sec_ack(sec_ack));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus cycle and helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        // read data taken at the answering edge, request released right after it
        rd_v = rdata;
        if (n >= 50) bad_count++;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(rd_v, {24'h0, e});
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            bus(1'b0, CFTF_OFS_CMD_STS, 8'h00);
            if (rd_v[CFTF_STS_BSY] === 1'b0) break;
        end
        // a command that never finishes counts as a mismatch
        if (rd_v[CFTF_STS_BSY] !== 1'b0) bad_count++;
    endtask

    task automatic issue(input logic [7:0] dh, sn, cl, ch, c);
        bus(1'b1, CFTF_OFS_DRVHEAD, dh);
        bus(1'b1, CFTF_OFS_SECNUM, sn);
        bus(1'b1, CFTF_OFS_CYL_LO, cl);
        bus(1'b1, CFTF_OFS_CYL_HI, ch);
        bus(1'b1, CFTF_OFS_CMD_STS, c);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #100000;
        bad_count++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        {rst_n, rd, wr, addr, wdata} = '0;
        delay = 4'h6;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd_chk(OFS[i], RSTV[i]);
        $display("test reset values done");
        bus(1'b1, CFTF_OFS_IRQ_MASK, 8'h03);
        bus(1'b1, CFTF_OFS_CMD_STS, CFTF_CMD_FLUSH_EXT);
        rd_chk(CFTF_OFS_CMD_STS, 8'h90);
        wait_idle();
        check(media_u.flush_cnt_r, 1);
        rd_chk(CFTF_OFS_CMD_STS, 8'h50);
        check(irq, 1'b1);
        bus(1'b1, CFTF_OFS_IRQ_STS, 8'h01);
        check(irq, 1'b0);
        $display("test flush done");
        bus(1'b1, CFTF_OFS_DRVHEAD, 8'hB0);
        bus(1'b1, CFTF_OFS_CMD_STS, CFTF_CMD_FLUSH_EXT);
        rd_chk(CFTF_OFS_CMD_STS, 8'h50);
        check(media_u.flush_cnt_r, 1);
        $display("test other drive done");
        delay <= 4'h1;
        repeat (3) bus(1'b1, CFTF_OFS_DATA, 8'h5A);
        rd_chk(CFTF_OFS_TBL_CNT, 8'h03);
        issue(8'hE0, 8'h1D, 8'h00, 8'h00, CFTF_CMD_FMT_TRACK);
        wait_idle();
        check(media_u.wr_cnt_r, 4);
        check(media_u.zeroed_r, 32'hF0000000);
        rd_chk(CFTF_OFS_SECNUM, 8'h1F);
        rd_chk(CFTF_OFS_CYL_LO, 8'h00);
        rd_chk(CFTF_OFS_DRVHEAD, 8'hE0);
        rd_chk(CFTF_OFS_FEAT_ERR, 8'h00);
        rd_chk(CFTF_OFS_IRQ_STS, 8'h01);
        bus(1'b1, CFTF_OFS_IRQ_STS, 8'h03);
        $display("test lba format done");
        issue(8'hE0, 8'h20, 8'h00, 8'h00, CFTF_CMD_FMT_TRACK);
        rd_chk(CFTF_OFS_FEAT_ERR, 8'h04);
        rd_chk(CFTF_OFS_CMD_STS, 8'h51);
        rd_chk(CFTF_OFS_IRQ_STS, 8'h03);
        check(media_u.wr_cnt_r, 4);
        bus(1'b1, CFTF_OFS_IRQ_STS, 8'h03);
        $display("test lba range done");
        delay <= 4'h6;
        issue(8'hA1, 8'h01, 8'h02, 8'h00, CFTF_CMD_FMT_TRACK);
        bus(1'b1, CFTF_OFS_SECNUM, 8'h55);
        wait_idle();
        check(media_u.wr_cnt_r, 8);
        check(media_u.zeroed_r, 32'hF0F00000);
        rd_chk(CFTF_OFS_SECNUM, 8'h01);
        $display("test chs format done");
        issue(8'hA2, 8'h01, 8'h00, 8'h00, CFTF_CMD_FMT_TRACK);
        rd_chk(CFTF_OFS_FEAT_ERR, 8'h10);
        issue(8'hA0, 8'h01, 8'h00, 8'h00, 8'hEC);
        rd_chk(CFTF_OFS_FEAT_ERR, 8'h04);
        check(irq, 1'b1);
        $display("test refused commands done");
        results();
    end
endmodule
